// [bench/irq_partner.sv]
// Behavioural model of the DSP core and the peripherals that raise requests
`timescale 1ns/1ps
module irq_partner (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Bench control
  input  wire logic [12:0] fire,
  input  wire logic        ack_en,
  input  wire logic [3:0]  ack_delay,
  // Device side
  input  wire logic        irq_request,
  output logic      [12:0] src,
  output logic             irq_ack
);
  logic [4:0] wait_reg;
  // Request lags an ack by two cycles, so the next ack waits past the stale one
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      src <= 13'h0000;
      irq_ack <= 1'b0;
      wait_reg <= 5'h00;
    end else begin
      src <= fire;
      if (irq_ack) begin
        irq_ack <= 1'b0;
        wait_reg <= {1'b0, ack_delay} + 5'h03;
      end else if (wait_reg != 5'h00) begin
        wait_reg <= wait_reg - 5'h01;
      end else begin
        irq_ack <= ack_en & irq_request;
      end
    end
  end
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the DSP interrupt vector map
`timescale 1ns/1ps
module tb_top;
  import irq_map_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  avs_response;
  logic [12:0] src;
  logic [12:0] fire = 13'h0;
  logic        ack_en = 1'b0;
  logic [3:0]  ack_delay = 4'h0;
  logic        irq_request;
  logic        irq_ack;
  logic [6:0]  irq_vector;
  logic [4:0]  irq_priority;
  int          n_errors = 0;
  int          samples_checked = 0;
  logic [33:0] rq[$];
  logic [12:0] iq[$];
  logic [31:0] seed = 32'h788A4C40;
  // Per source: flag bit, slot, priority, select value that routes it
  logic [3:0]  t_bit[13] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'hA, 4'hB, 4'h9, 4'h6, 4'h7, 4'hA, 4'hB, 4'hC, 4'hD};
  logic [6:0]  t_vec[13] = '{7'h40, 7'h4C, 7'h50, 7'h54, 7'h68, 7'h6C, 7'h64, 7'h58, 7'h5C, 7'h68, 7'h6C, 7'h70, 7'h74};
  logic [4:0]  t_pri[13] = '{5'h03, 5'h06, 5'h07, 5'h08, 5'h0D, 5'h0E, 5'h0C, 5'h09, 5'h0A, 5'h0D, 5'h0E, 5'h0F, 5'h10};
  logic [1:0]  t_sel[13] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0};

  dsp_interrupt_vector_map dut (.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .ext_line0_irq(src[0]), .timer_irq(src[1]), .serial0_rx_irq(src[2]), .serial0_tx_irq(src[3]),
    .serial1_rx_irq(src[4]), .serial1_tx_irq(src[5]), .host_mailbox_irq(src[6]), .dma_ch0_irq(src[7]),
    .dma_ch1_irq(src[8]), .dma_ch2_irq(src[9]), .dma_ch3_irq(src[10]), .dma_ch4_irq(src[11]),
    .dma_ch5_irq(src[12]), .irq_request(irq_request), .irq_vector(irq_vector),
    .irq_priority(irq_priority), .irq_ack(irq_ack));

  irq_partner core (.clk(clk), .resetn(resetn), .fire(fire), .ack_en(ack_en), .ack_delay(ack_delay),
    .irq_request(irq_request), .src(src), .irq_ack(irq_ack));

  always #5 clk = ~clk;

  function automatic logic [31:0] xs(logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic chk(string nm, logic [33:0] e, logic [33:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic bus_rd(logic [3:0] a, logic [33:0] e);
    @(posedge clk);
    rq.push_back(e);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
  endtask

  task automatic bus_wr(logic [3:0] a, logic [31:0] d, logic [3:0] be);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task automatic pulse(logic [12:0] f);
    @(posedge clk);
    fire <= f;
    @(posedge clk);
    fire <= 13'h0;
  endtask

  // Bounded wait until every noted request has been taken and the line drops
  task automatic drain();
    int n;
    n = 0;
    while ((iq.size() != 0 || irq_request !== 1'b0) && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) chk("drain", 34'h0, 34'h1);
    repeat (2) @(posedge clk);
  endtask

  // Oldest note is compared whenever a read completes or the core takes a vector
  always @(posedge clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) chk("readdata", rq.pop_front(), {avs_response, avs_readdata});
    if (irq_ack === 1'b1) chk("vector", {21'h0, iq.pop_front()}, {21'h0, irq_request, irq_vector, irq_priority});
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    close_out();
  end

  initial begin
    logic [12:0] s;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    bus_rd(4'h0, 34'h0);
    bus_rd(4'h1, 34'h0);
    bus_rd(4'h2, 34'h0);
    bus_wr(4'h7, 32'hFFFF, 4'hF);
    bus_rd(4'h7, {2'b11, 32'h0});
    bus_wr(4'h1, 32'hFFFF, 4'h1);
    bus_rd(4'h1, 34'h00F9);
    bus_wr(4'h1, 32'hFFFF, 4'h3);
    bus_rd(4'h1, 34'h3EF9);
    pulse(13'h0002);
    bus_rd(4'h0, 34'h0008);
    bus_rd(4'h3, 34'h06CC);
    bus_wr(4'h0, 32'h0008, 4'hF);
    bus_rd(4'h0, 34'h0);
    pulse(13'h0780);
    bus_rd(4'h0, 34'h0);
    bus_wr(4'h2, 32'h1, 4'hF);
    pulse(13'h01B0);
    bus_rd(4'h0, 34'h0);
    ack_en <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      bus_wr(4'h2, {30'h0, t_sel[i]}, 4'hF);
      iq.push_back({1'b1, t_vec[i], t_pri[i]});
      pulse(13'h1 << i);
      drain();
      bus_rd(4'h0, 34'h0);
    end
    // Serial 1 sources are left out here since the select hands their bits to DMA
    bus_wr(4'h2, 32'h2, 4'hF);
    for (int r = 0; r < 8; r++) begin
      seed = xs(seed);
      ack_delay <= seed[19:16];
      s = seed[12:0] & 13'h1FCF;
      for (int b = 0; b < 14; b++) begin
        for (int i = 0; i < 13; i++) begin
          if (s[i] && t_bit[i] == b) iq.push_back({1'b1, t_vec[i], t_pri[i]});
        end
      end
      pulse(s);
      drain();
    end
    close_out();
  end
endmodule

// [logic/dsp_interrupt_vector_map.sv]
// DSP interrupt flag, mask, source select and vector logic
// Function
// - Slots four words apart; reset at 00
// - External line 0: slot 40, priority 3
// - Timer at bit 3, slot 4C, priority 6
// - Serial 0 receive: slot 50, priority 7
// - Serial 0 transmit: slot 54, priority 8
// - DMA 0 / soft 6: slot 58, priority 9
// - DMA 1 / soft 7: slot 5C, priority 10
// - Slot 68: serial 1 rx or DMA 2
// - Slot 6C: serial 1 tx or DMA 3
// - DMA 4: slot 70, priority 15
// - DMA 5: slot 74, lowest priority 16
// - Shared layout; reserved bits; mailbox bit 9
// - External line 0 at bit 0
// - DMA 5 bit 13, DMA 4 bit 12
// - Serial 1 tx bit 11, rx bit 10
// - DMA 1 bit 7, DMA 0 bit 6
// - Serial 0 tx bit 5, rx bit 4
// - Select field picks sources for shared bits
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module dsp_interrupt_vector_map
  import irq_map_pkg::*;
(
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          resetn,
  // Avalon-MM slave
  input  wire logic [irq_map_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic      [31:0]                   avs_readdata,
  output logic                               avs_waitrequest,
  output logic      [1:0]                    avs_response,
  // Interrupt sources, one-cycle pulses
  input  wire logic                          ext_line0_irq,
  input  wire logic                          timer_irq,
  input  wire logic                          serial0_rx_irq,
  input  wire logic                          serial0_tx_irq,
  input  wire logic                          serial1_rx_irq,
  input  wire logic                          serial1_tx_irq,
  input  wire logic                          host_mailbox_irq,
  input  wire logic                          dma_ch0_irq,
  input  wire logic                          dma_ch1_irq,
  input  wire logic                          dma_ch2_irq,
  input  wire logic                          dma_ch3_irq,
  input  wire logic                          dma_ch4_irq,
  input  wire logic                          dma_ch5_irq,
  // Core side
  output logic                               irq_request,
  output logic      [6:0]                    irq_vector,
  output logic      [4:0]                    irq_priority,
  input  wire logic                          irq_ack
);
  import irq_map_pkg::*;

  typedef enum logic {BUS_IDLE, BUS_DONE} bus_state_e;

  logic [15:0] flags_reg, flags_next;
  logic [15:0] masks_reg, masks_next;
  logic [1:0]  sel_reg, sel_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  resp_reg, resp_next;
  bus_state_e  bus_reg, bus_next;
  logic        req_reg, req_next;
  logic [6:0]  vec_reg, vec_next;
  logic [4:0]  pri_reg, pri_next;
  logic [3:0]  win_reg, win_next;
  logic [15:0] raw_req;
  logic [15:0] pending;
  logic        found;
  logic [3:0]  win_bit;
  logic        bus_take;
  logic        wr_flags, wr_masks, wr_sel;

  // Vector slot for a flag bit position
  function automatic logic [6:0] bit_vector(input logic [3:0] b);
    case (b)
      4'h0:    bit_vector = VEC_EXT0;
      4'h3:    bit_vector = VEC_TIMER;
      4'h4:    bit_vector = VEC_SER0_RX;
      4'h5:    bit_vector = VEC_SER0_TX;
      4'h6:    bit_vector = VEC_DMA0;
      4'h7:    bit_vector = VEC_DMA1;
      4'h9:    bit_vector = VEC_MAILBOX;
      4'hA:    bit_vector = VEC_SER1_RX;
      4'hB:    bit_vector = VEC_SER1_TX;
      4'hC:    bit_vector = VEC_DMA4;
      4'hD:    bit_vector = VEC_DMA5;
      default: bit_vector = VEC_RESET;
    endcase
  endfunction

  // Priority for a flag bit position
  function automatic logic [4:0] bit_priority(input logic [3:0] b);
    case (b)
      4'h0:    bit_priority = PRI_EXT0;
      4'h3:    bit_priority = PRI_TIMER;
      4'h4:    bit_priority = PRI_SER0_RX;
      4'h5:    bit_priority = PRI_SER0_TX;
      4'h6:    bit_priority = PRI_DMA0;
      4'h7:    bit_priority = PRI_DMA1;
      4'h9:    bit_priority = PRI_MAILBOX;
      4'hA:    bit_priority = PRI_SER1_RX;
      4'hB:    bit_priority = PRI_SER1_TX;
      4'hC:    bit_priority = PRI_DMA4;
      4'hD:    bit_priority = PRI_DMA5;
      default: bit_priority = PRI_RESET;
    endcase
  endfunction

  // Source routing into flag positions
  always_comb begin
    raw_req              = 16'h0000;
    raw_req[BIT_EXT0]    = ext_line0_irq;
    raw_req[BIT_TIMER]   = timer_irq;
    raw_req[BIT_SER0_RX] = serial0_rx_irq;
    raw_req[BIT_SER0_TX] = serial0_tx_irq;
    raw_req[BIT_MAILBOX] = host_mailbox_irq;
    raw_req[BIT_DMA4]    = dma_ch4_irq;
    raw_req[BIT_DMA5]    = dma_ch5_irq;
    case (sel_reg)
      SEL_SERIAL1: begin
        raw_req[BIT_SER1_RX] = serial1_rx_irq;
        raw_req[BIT_SER1_TX] = serial1_tx_irq;
      end
      SEL_DMA23: begin
        raw_req[BIT_SER1_RX] = dma_ch2_irq;
        raw_req[BIT_SER1_TX] = dma_ch3_irq;
      end
      SEL_DMA0123: begin
        raw_req[BIT_SER1_RX] = dma_ch2_irq;
        raw_req[BIT_SER1_TX] = dma_ch3_irq;
        raw_req[BIT_DMA0]    = dma_ch0_irq;
        raw_req[BIT_DMA1]    = dma_ch1_irq;
      end
      default: begin
        // Value 11b leaves all shared positions unconnected
        raw_req[BIT_SER1_RX] = 1'b0;
      end
    endcase
  end

  // Lowest bit position holds the highest priority
  assign pending = flags_reg & masks_reg & IMPL_MASK;
  always_comb begin
    found   = 1'b0;
    win_bit = 4'h0;
    for (int i = NUM_BITS - 1; i >= 0; i--) begin
      if (pending[i]) begin
        found   = 1'b1;
        win_bit = i[3:0];
      end
    end
  end

  // Bus decode; every access finishes in the cycle after it is seen
  assign bus_take = (bus_reg == BUS_IDLE) && (avs_read || avs_write);
  // Writes land only at the edge that ends the wait, when the master takes the answer
  assign wr_flags = (bus_reg == BUS_DONE) && avs_write && (avs_address == FLAGS_IDX);
  assign wr_masks = (bus_reg == BUS_DONE) && avs_write && (avs_address == MASKS_IDX);
  assign wr_sel   = (bus_reg == BUS_DONE) && avs_write && (avs_address == DMA_PRIO_IDX) && avs_byteenable[0];

  always_comb begin
    logic [15:0] wmask;
    logic [15:0] clr;
    wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    clr   = 16'h0000;
    // Software writes 1 to clear a flag
    if (wr_flags) begin
      clr = avs_writedata[15:0] & wmask;
    end
    // Acknowledge clears the flag that was presented
    if (irq_ack && req_reg) begin
      clr[win_reg] = 1'b1;
    end
    // Set wins over clear so a request in the clearing cycle is kept
    flags_next = ((flags_reg & ~clr) | raw_req) & IMPL_MASK;
    masks_next = masks_reg;
    if (wr_masks) begin
      masks_next = ((masks_reg & ~wmask) | (avs_writedata[15:0] & wmask)) & IMPL_MASK;
    end
    sel_next = wr_sel ? avs_writedata[SEL_LSB +: 2] : sel_reg;
  end

  always_comb begin
    bus_next   = BUS_IDLE;
    rdata_next = rdata_reg;
    resp_next  = 2'h0;
    if (bus_take) begin
      bus_next   = BUS_DONE;
      rdata_next = 32'h0000_0000;
      if (avs_address > VECTOR_IDX) begin
        resp_next = 2'h3;
      end
      if (avs_read) begin
        case (avs_address)
          FLAGS_IDX:    rdata_next = {16'h0000, flags_reg & IMPL_MASK};
          MASKS_IDX:    rdata_next = {16'h0000, masks_reg & IMPL_MASK};
          DMA_PRIO_IDX: rdata_next = {30'h0, sel_reg};
          VECTOR_IDX:   rdata_next = {19'h0, pri_reg, req_reg, vec_reg};
          default:      rdata_next = 32'h0000_0000;
        endcase
      end
    end
  end

  // Presented request is registered
  always_comb begin
    req_next = found;
    win_next = win_bit;
    vec_next = found ? bit_vector(win_bit) : VEC_RESET;
    pri_next = found ? bit_priority(win_bit) : PRI_RESET;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags_reg <= FLAGS_RESET;
      masks_reg <= MASKS_RESET;
      sel_reg   <= SEL_RESET;
      rdata_reg <= 32'h0000_0000;
      resp_reg  <= 2'h0;
      bus_reg   <= BUS_IDLE;
      req_reg   <= 1'b0;
      win_reg   <= 4'h0;
      vec_reg   <= VEC_RESET;
      pri_reg   <= PRI_RESET;
    end else begin
      flags_reg <= flags_next;
      masks_reg <= masks_next;
      sel_reg   <= sel_next;
      rdata_reg <= rdata_next;
      resp_reg  <= resp_next;
      bus_reg   <= bus_next;
      req_reg   <= req_next;
      win_reg   <= win_next;
      vec_reg   <= vec_next;
      pri_reg   <= pri_next;
    end
  end

  // An ack in the same cycle a new winner forms may retire the old one only
  assign irq_request     = req_reg;
  assign irq_vector      = vec_reg;
  assign irq_priority    = pri_reg;
  assign avs_readdata    = rdata_reg;
  assign avs_response    = resp_reg;
  assign avs_waitrequest = (avs_read || avs_write) && (bus_reg == BUS_IDLE);

  chk_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
    ((flags_reg | masks_reg) & ~IMPL_MASK) == 16'h0000) else $error("reserved bit set");
  chk_timer_sets: assert property (@(posedge clk) disable iff (!resetn)
    timer_irq |=> flags_reg[3]) else $error("timer flag not set");
  chk_ext0_vector: assert property (@(posedge clk) disable iff (!resetn)
    (flags_reg[0] && masks_reg[0]) |=> (irq_request && irq_vector == 7'h40 && irq_priority == 5'h03))
    else $error("external line 0 vector wrong");
  chk_dma5_lowest: assert property (@(posedge clk) disable iff (!resetn)
    (irq_request && irq_vector == 7'h74) |-> (irq_priority == 5'h10 && $past(pending) == 16'h2000))
    else $error("dma 5 shown over another source");
  chk_no_rsvd_slot: assert property (@(posedge clk) disable iff (!resetn)
    irq_request |-> (irq_vector < VEC_RSVD_LO && irq_vector >= VEC_EXT0)) else $error("reserved slot used");
  chk_sel_reset_dma0: assert property (@(posedge clk) disable iff (!resetn)
    (sel_reg != SEL_DMA0123 && !flags_reg[6]) |=> !flags_reg[6]) else $error("dma 0 flag while deselected");
  chk_serial1_rx: assert property (@(posedge clk) disable iff (!resetn)
    (sel_reg == SEL_SERIAL1 && serial1_rx_irq) |=> flags_reg[10]) else $error("serial 1 rx lost");
  chk_ack_clears: assert property (@(posedge clk) disable iff (!resetn)
    (irq_ack && irq_request && win_reg == 4'h4 && !serial0_rx_irq) |=> !flags_reg[4])
    else $error("ack did not clear flag");
  chk_wait_one: assert property (@(posedge clk) disable iff (!resetn)
    (avs_read && avs_waitrequest) |=> !avs_waitrequest) else $error("bus answer late");

  chk_ext0_sets: assert property (@(posedge clk) disable iff (!resetn)
    ext_line0_irq |=> flags_reg[0])
    else $error("external line 0 flag not set");

  chk_ser0_rx_sets: assert property (@(posedge clk) disable iff (!resetn)
    serial0_rx_irq |=> flags_reg[4])
    else $error("serial 0 rx flag not set");

  chk_ser0_tx_sets: assert property (@(posedge clk) disable iff (!resetn)
    serial0_tx_irq |=> flags_reg[5])
    else $error("serial 0 tx flag not set");

  chk_mailbox_sets: assert property (@(posedge clk) disable iff (!resetn)
    host_mailbox_irq |=> flags_reg[9])
    else $error("mailbox flag not set");

  chk_dma4_sets: assert property (@(posedge clk) disable iff (!resetn)
    dma_ch4_irq |=> flags_reg[12])
    else $error("dma 4 flag not set");

  chk_dma5_sets: assert property (@(posedge clk) disable iff (!resetn)
    dma_ch5_irq |=> flags_reg[13])
    else $error("dma 5 flag not set");

  chk_serial1_tx: assert property (@(posedge clk) disable iff (!resetn)
    (sel_reg == SEL_SERIAL1 && serial1_tx_irq) |=> flags_reg[11])
    else $error("serial 1 tx lost");

  chk_dma2_routed: assert property (@(posedge clk) disable iff (!resetn)
    ((sel_reg == SEL_DMA23 || sel_reg == SEL_DMA0123) && dma_ch2_irq) |=> flags_reg[10])
    else $error("dma 2 lost");

  chk_dma3_routed: assert property (@(posedge clk) disable iff (!resetn)
    ((sel_reg == SEL_DMA23 || sel_reg == SEL_DMA0123) && dma_ch3_irq) |=> flags_reg[11])
    else $error("dma 3 lost");

  chk_dma0_routed: assert property (@(posedge clk) disable iff (!resetn)
    (sel_reg == SEL_DMA0123 && dma_ch0_irq) |=> flags_reg[6])
    else $error("dma 0 lost");

  chk_dma1_routed: assert property (@(posedge clk) disable iff (!resetn)
    (sel_reg == SEL_DMA0123 && dma_ch1_irq) |=> flags_reg[7])
    else $error("dma 1 lost");

  chk_dma1_deselect: assert property (@(posedge clk) disable iff (!resetn)
    (sel_reg != SEL_DMA0123 && !flags_reg[7]) |=> !flags_reg[7])
    else $error("dma 1 flag while deselected");

  chk_timer_prio: assert property (@(posedge clk) disable iff (!resetn)
    (irq_request && irq_vector == 7'h4C) |-> irq_priority == 5'h06)
    else $error("timer priority wrong");

  chk_ser0_rx_prio: assert property (@(posedge clk) disable iff (!resetn)
    (irq_request && irq_vector == 7'h50) |-> irq_priority == 5'h07)
    else $error("serial 0 rx priority wrong");

  chk_ser0_tx_prio: assert property (@(posedge clk) disable iff (!resetn)
    (irq_request && irq_vector == 7'h54) |-> irq_priority == 5'h08)
    else $error("serial 0 tx priority wrong");

  chk_dma0_prio: assert property (@(posedge clk) disable iff (!resetn)
    (irq_request && irq_vector == 7'h58) |-> irq_priority == 5'h09)
    else $error("dma 0 priority wrong");

  chk_dma1_prio: assert property (@(posedge clk) disable iff (!resetn)
    (irq_request && irq_vector == 7'h5C) |-> irq_priority == 5'h0A)
    else $error("dma 1 priority wrong");

  chk_slot68_prio: assert property (@(posedge clk) disable iff (!resetn)
    (irq_request && irq_vector == 7'h68) |-> irq_priority == 5'h0D)
    else $error("slot 68 priority wrong");

  chk_slot6c_prio: assert property (@(posedge clk) disable iff (!resetn)
    (irq_request && irq_vector == 7'h6C) |-> irq_priority == 5'h0E)
    else $error("slot 6C priority wrong");

  chk_dma4_prio: assert property (@(posedge clk) disable iff (!resetn)
    (irq_request && irq_vector == 7'h70) |-> irq_priority == 5'h0F)
    else $error("dma 4 priority wrong");

  chk_idle_vector: assert property (@(posedge clk) disable iff (!resetn)
    !irq_request |-> (irq_vector == VEC_RESET && irq_priority == PRI_RESET))
    else $error("idle vector not at slot 00");

  chk_slot_aligned: assert property (@(posedge clk) disable iff (!resetn)
    irq_request |-> irq_vector[1:0] == 2'b00)
    else $error("slot not four words apart");

  chk_request_follows: assert property (@(posedge clk) disable iff (!resetn)
    (|pending) |=> irq_request)
    else $error("pending request not presented");

  chk_request_drops: assert property (@(posedge clk) disable iff (!resetn)
    !(|pending) |=> !irq_request)
    else $error("request shown with nothing pending");

  chk_flags_rsvd_read: assert property (@(posedge clk) disable iff (!resetn)
    (avs_read && !avs_waitrequest && avs_address == FLAGS_IDX) |-> (avs_readdata[15:0] & ~IMPL_MASK) == 16'h0000)
    else $error("reserved flag bit read as one");

  // Unmapped words answer with an error code so software can tell a bad pointer
  chk_resp_error: assert property (@(posedge clk) disable iff (!resetn)
    (avs_read && !avs_waitrequest && avs_address > VECTOR_IDX) |-> avs_response == 2'h3)
    else $error("unmapped read not flagged");
endmodule

// [logic/irq_map_pkg.sv]
// Constants for the DSP interrupt vector map block
package irq_map_pkg;
  localparam int          NUM_BITS        = 16;
  localparam int          ADDR_W          = 4;
  // Register word addresses (byte address = 4 * index)
  localparam logic [3:0]  FLAGS_IDX       = 4'h0;
  localparam logic [3:0]  MASKS_IDX       = 4'h1;
  localparam logic [3:0]  DMA_PRIO_IDX    = 4'h2;
  localparam logic [3:0]  VECTOR_IDX      = 4'h3;
  // Bit positions in flags and masks
  localparam int          BIT_EXT0        = 0;
  localparam int          BIT_TIMER       = 3;
  localparam int          BIT_SER0_RX     = 4;
  localparam int          BIT_SER0_TX     = 5;
  localparam int          BIT_DMA0        = 6;
  localparam int          BIT_DMA1        = 7;
  localparam int          BIT_MAILBOX     = 9;
  localparam int          BIT_SER1_RX     = 10;
  localparam int          BIT_SER1_TX     = 11;
  localparam int          BIT_DMA4        = 12;
  localparam int          BIT_DMA5        = 13;
  // Implemented bits; 15-14, 8 and 2-1 are reserved
  localparam logic [15:0] IMPL_MASK       = 16'h3EF9;
  localparam logic [15:0] FLAGS_RESET     = 16'h0000;
  localparam logic [15:0] MASKS_RESET     = 16'h0000;
  // Select field of the DMA priority control register
  localparam int          SEL_LSB         = 0;
  localparam logic [1:0]  SEL_RESET       = 2'h0;
  localparam logic [1:0]  SEL_SERIAL1     = 2'h0;
  localparam logic [1:0]  SEL_DMA23       = 2'h1;
  localparam logic [1:0]  SEL_DMA0123     = 2'h2;
  // Vector slots
  localparam logic [6:0]  VEC_RESET       = 7'h00;
  localparam logic [6:0]  VEC_SOFT16      = 7'h04;
  localparam logic [6:0]  VEC_SOFT30      = 7'h3C;
  localparam logic [6:0]  VEC_EXT0        = 7'h40;
  localparam logic [6:0]  VEC_TIMER       = 7'h4C;
  localparam logic [6:0]  VEC_SER0_RX     = 7'h50;
  localparam logic [6:0]  VEC_SER0_TX     = 7'h54;
  localparam logic [6:0]  VEC_DMA0        = 7'h58;
  localparam logic [6:0]  VEC_DMA1        = 7'h5C;
  localparam logic [6:0]  VEC_MAILBOX     = 7'h64;
  localparam logic [6:0]  VEC_SER1_RX     = 7'h68;
  localparam logic [6:0]  VEC_SER1_TX     = 7'h6C;
  localparam logic [6:0]  VEC_DMA4        = 7'h70;
  localparam logic [6:0]  VEC_DMA5        = 7'h74;
  localparam logic [6:0]  VEC_RSVD_LO     = 7'h78;
  // Priorities, 1 is highest
  localparam logic [4:0]  PRI_RESET       = 5'h01;
  localparam logic [4:0]  PRI_EXT0        = 5'h03;
  localparam logic [4:0]  PRI_TIMER       = 5'h06;
  localparam logic [4:0]  PRI_SER0_RX     = 5'h07;
  localparam logic [4:0]  PRI_SER0_TX     = 5'h08;
  localparam logic [4:0]  PRI_DMA0        = 5'h09;
  localparam logic [4:0]  PRI_DMA1        = 5'h0A;
  localparam logic [4:0]  PRI_MAILBOX     = 5'h0C;
  localparam logic [4:0]  PRI_SER1_RX     = 5'h0D;
  localparam logic [4:0]  PRI_SER1_TX     = 5'h0E;
  localparam logic [4:0]  PRI_DMA4        = 5'h0F;
  localparam logic [4:0]  PRI_DMA5        = 5'h10;
endpackage
